// >>> counter_cmd_map.svh
`ifndef COUNTER_CMD_MAP_SVH
`define COUNTER_CMD_MAP_SVH

// ****************************************
// Command register indices and byte addresses
// ****************************************
`define CMD_IDX0        12'h00C
`define CMD_IDX1        12'h00E
`define CMD_IDX2        12'h10C
`define CMD_IDX3        12'h10E
`define CMD_ADDR0       (14'(`CMD_IDX0) << 2)
`define CMD_ADDR1       (14'(`CMD_IDX1) << 2)
`define CMD_ADDR2       (14'(`CMD_IDX2) << 2)
`define CMD_ADDR3       (14'(`CMD_IDX3) << 2)

// ****************************************
// Per-counter auxiliary register window
// ****************************************
`define AUX_BASE        14'h0800
`define AUX_STRIDE      14'h0010
`define AUX_LOAD_A      14'h0000
`define AUX_LOAD_B      14'h0004
`define AUX_SNAPSHOT    14'h0008
`define AUX_STATUS      14'h000C

// ****************************************
// Command register field positions
// ****************************************
`define BIT_PARTNER_DISARM      15
`define BIT_PARTNER_LATCH_HOLD  14
`define BIT_PARTNER_ARM         13
`define BIT_ALT_ENABLE          12
`define BIT_ALT_TRIGGER         11
`define BIT_ALT_GO              10
`define BIT_ACK_HALF            9
`define BIT_GATE_RESYNC         8
`define BIT_WRITE_REDIRECT      7
`define BIT_DIR_HI              6
`define BIT_DIR_LO              5
`define BIT_SELF_DISARM         4
`define BIT_PRELOAD_STROBE      2
`define BIT_LATCH_HOLD          1
`define BIT_SELF_ARM            0

// ****************************************
// Status register field positions and reset values
// ****************************************
`define ST_ARMED        0
`define ST_LATCH_DONE   1
`define ST_BANK         2
`define ST_GATE         3
`define ST_DIR_UP       4
`define ST_ALT_PENDING  5
`define RESET_WORD      32'h0000_0000
`define RESET_CFG       8'h00

`endif

// >>> counter_cmd_pkg.sv
package counter_cmd_pkg;

	typedef enum logic [1:0]
	{
		DIR_DOWN = 2'b00,
		DIR_UP   = 2'b01,
		DIR_PIN  = 2'b10,
		DIR_GATE = 2'b11
	} dir_type;

	typedef enum logic [1:0]
	{
		LATCH_TRACE = 2'b00,
		LATCH_GRAB  = 2'b01,
		LATCH_DONE  = 2'b10
	} latch_type;

	typedef struct packed
	{
		logic    alt_enable;
		logic    alt_trigger;
		logic    ack_half;
		logic    resync;
		logic    redirect;
		dir_type dir;
		logic    spare;
	} cmd_cfg_type;

	typedef struct packed
	{
		logic        valid;
		logic        write;
		logic [13:0] addr;
	} bus_phase_type;

endpackage

// >>> counter_pair_command.sv
`timescale 1ns/1ps
`include "counter_cmd_map.svh"
// Functional notes
// - four 16-bit write-only command registers, fixed offsets
// - bit 15 disarms the partner counter
// - bit 14 traces or latches partner snapshot
// - bit 13 arms partner until disarmed
// - bit 12 lets armed counter alternate banks
// - disarmed, bit 12 picks written bank
// - bit 11 picks gate or software switch
// - bit 10 requests switch, clears itself after
// - bit 9 picks half triggering acknowledge
// - bit 8 resynchronises gate to counter clock
// - bit 7 redirects load A and load B writes to inactive bank while armed
// - bit 0 arms counter until disarmed
// - bit 4 disarms the counter itself
// - bit 2 loads selected register into counter
// - bits 6:5 select count direction

module counter_pair_command
	import counter_cmd_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [3:0]  count_source_input,
	input  wire logic [3:0]  gate_pin,
	input  wire logic [3:0]  updown_pin,
	output logic      [3:0]  ack_half_select,
	output logic      [3:0]  active_bank
);

	localparam logic [13:0] CMD_ADDR [4] =
		'{`CMD_ADDR0, `CMD_ADDR1, `CMD_ADDR2, `CMD_ADDR3};

	// ****************************************
	// Bus slave
	// ****************************************
	bus_phase_type dphase_reg;
	logic [31:0]   rd_next;
	logic [3:0]    cmd_wr;
	logic [3:0]    load_a_wr;
	logic [3:0]    load_b_wr;
	logic [15:0]   cmd_data;
	logic [31:0]   aux_word [4][4];

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			dphase_reg <= '0;
		else if (hready)
		begin
			dphase_reg.valid <= hsel && htrans[1];
			dphase_reg.write <= hwrite;
			dphase_reg.addr  <= haddr[13:0];
		end
	end

	// Command registers are write-only and read as zero
	always_comb
	begin
		rd_next = `RESET_WORD;
		for (int k = 0; k < 4; k++)
		begin
			for (int r = 0; r < 4; r++)
			begin
				if (haddr[13:0] == `AUX_BASE + 14'(k) * `AUX_STRIDE
					+ 14'(r) * 14'h0004)
					rd_next = aux_word[k][r];
			end
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			hrdata <= `RESET_WORD;
		else if (hready && hsel && htrans[1] && !hwrite)
			hrdata <= rd_next;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Each data-phase write to a command or load register becomes a one-cycle pulse
	always_comb
	begin
		cmd_data = hwdata[15:0];
		for (int k = 0; k < 4; k++)
		begin
			cmd_wr[k] = dphase_reg.valid && dphase_reg.write
				&& dphase_reg.addr == CMD_ADDR[k];
			load_a_wr[k] = dphase_reg.valid && dphase_reg.write
				&& dphase_reg.addr == `AUX_BASE
				+ 14'(k) * `AUX_STRIDE + `AUX_LOAD_A;
			load_b_wr[k] = dphase_reg.valid && dphase_reg.write
				&& dphase_reg.addr == `AUX_BASE
				+ 14'(k) * `AUX_STRIDE + `AUX_LOAD_B;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// ****************************************
	// Per-counter command logic
	// ****************************************
	cmd_cfg_type cfg_reg       [4];
	logic [31:0] count_reg     [4];
	logic [31:0] snapshot_reg  [4];
	logic [31:0] load_a_reg    [4][2];
	logic [31:0] load_b_reg    [4][2];
	latch_type   latch_reg     [4];
	logic [3:0]  armed_reg;
	logic [3:0]  hold_reg;
	logic [3:0]  pending_reg;
	logic [3:0]  gate_prev_reg;
	logic [3:0]  src_prev_reg;
	logic [3:0]  gate_sync;
	logic [3:0]  updown_sync;
	logic [3:0]  source_sync;
	logic [3:0]  gate_used;
	logic [3:0]  dir_up;
	logic [3:0]  arm_req;
	logic [3:0]  disarm_req;
	logic [3:0]  switch_now;
	logic [3:0]  go_set;
	logic [3:0]  write_bank;

	genvar i;
	generate
	for (i = 0; i < 4; i++)
	begin : g_counter
		localparam int P = i ^ 1;

		input_sync u_gate_sync
		(
			.clk   (clk),
			.rstn  (rstn),
			.pin   (gate_pin[i]),
			.level (gate_sync[i])
		);
		input_sync u_updown_sync
		(
			.clk   (clk),
			.rstn  (rstn),
			.pin   (updown_pin[i]),
			.level (updown_sync[i])
		);
		input_sync u_source_sync
		(
			.clk   (clk),
			.rstn  (rstn),
			.pin   (count_source_input[i]),
			.level (source_sync[i])
		);

		assign gate_used[i] = cfg_reg[i].resync ? gate_sync[i]
			: gate_pin[i];
		assign arm_req[i] = (cmd_wr[i] && cmd_data[`BIT_SELF_ARM])
			|| (cmd_wr[P] && cmd_data[`BIT_PARTNER_ARM]);
		assign disarm_req[i] = (cmd_wr[i] && cmd_data[`BIT_SELF_DISARM])
			|| (cmd_wr[P] && cmd_data[`BIT_PARTNER_DISARM]);
		assign go_set[i] = cmd_wr[i] && cmd_data[`BIT_ALT_GO];
		assign switch_now[i] = pending_reg[i] && armed_reg[i]
			&& cfg_reg[i].alt_enable && (cfg_reg[i].alt_trigger
			|| (gate_used[i] && !gate_prev_reg[i]));
		assign write_bank[i] = !armed_reg[i] ? cfg_reg[i].alt_enable
			: (cfg_reg[i].redirect ? !active_bank[i]
			: active_bank[i]);

		always_comb
		begin
			case (cfg_reg[i].dir)
			DIR_DOWN: dir_up[i] = 1'b0;
			DIR_UP:   dir_up[i] = 1'b1;
			DIR_PIN:  dir_up[i] = updown_sync[i];
			DIR_GATE: dir_up[i] = gate_used[i];
			default:  dir_up[i] = 1'b0;
			endcase
		end

		// Bit 3 is never looked at
		always_ff @(posedge clk or negedge rstn)
		begin
			if (!rstn)
				cfg_reg[i] <= `RESET_CFG;
			else if (cmd_wr[i])
			begin
				cfg_reg[i].alt_enable  <= cmd_data[`BIT_ALT_ENABLE];
				cfg_reg[i].alt_trigger <= cmd_data[`BIT_ALT_TRIGGER];
				cfg_reg[i].ack_half    <= cmd_data[`BIT_ACK_HALF];
				cfg_reg[i].resync      <= cmd_data[`BIT_GATE_RESYNC];
				cfg_reg[i].redirect    <= cmd_data[`BIT_WRITE_REDIRECT];
				cfg_reg[i].dir <= dir_type'(cmd_data[`BIT_DIR_HI:`BIT_DIR_LO]);
				cfg_reg[i].spare       <= 1'b0;
			end
		end

		always_ff @(posedge clk or negedge rstn)
		begin
			if (!rstn)
				ack_half_select[i] <= 1'b0;
			else if (cmd_wr[i])
				ack_half_select[i] <= cmd_data[`BIT_ACK_HALF];
		end

		// Disarm wins over a simultaneous arm
		always_ff @(posedge clk or negedge rstn)
		begin
			if (!rstn)
				armed_reg[i] <= 1'b0;
			else if (disarm_req[i])
				armed_reg[i] <= 1'b0;
			else if (arm_req[i])
				armed_reg[i] <= 1'b1;
		end

		// A new request wins over the clear of a finished switch
		always_ff @(posedge clk or negedge rstn)
		begin
			if (!rstn)
				pending_reg[i] <= 1'b0;
			else if (go_set[i])
				pending_reg[i] <= 1'b1;
			else if (switch_now[i])
				pending_reg[i] <= 1'b0;
		end

		always_ff @(posedge clk or negedge rstn)
		begin
			if (!rstn)
				active_bank[i] <= 1'b0;
			else if (!armed_reg[i])
				active_bank[i] <= cfg_reg[i].alt_enable;
			else if (switch_now[i])
				active_bank[i] <= !active_bank[i];
		end

		always_ff @(posedge clk or negedge rstn)
		begin
			if (!rstn)
			begin
				gate_prev_reg[i] <= 1'b0;
				src_prev_reg[i]  <= 1'b0;
			end
			else
			begin
				gate_prev_reg[i] <= gate_used[i];
				src_prev_reg[i]  <= source_sync[i];
			end
		end

		always_ff @(posedge clk or negedge rstn)
		begin
			if (!rstn)
			begin
				load_a_reg[i] <= '{`RESET_WORD, `RESET_WORD};
				load_b_reg[i] <= '{`RESET_WORD, `RESET_WORD};
			end
			else if (load_a_wr[i])
				load_a_reg[i][write_bank[i]] <= hwdata;
			else if (load_b_wr[i])
				load_b_reg[i][write_bank[i]] <= hwdata;
		end

		always_ff @(posedge clk or negedge rstn)
		begin
			if (!rstn)
				count_reg[i] <= `RESET_WORD;
			else if (cmd_wr[i] && cmd_data[`BIT_PRELOAD_STROBE])
				count_reg[i] <= load_a_reg[i][active_bank[i]];
			else if (armed_reg[i] && source_sync[i] && !src_prev_reg[i])
				count_reg[i] <= dir_up[i] ? count_reg[i] + 32'h0000_0001
					: count_reg[i] - 32'h0000_0001;
		end

		// Hold level comes from own bit 1 or the partner's bit 14
		always_ff @(posedge clk or negedge rstn)
		begin
			if (!rstn)
				hold_reg[i] <= 1'b0;
			else if (cmd_wr[i])
				hold_reg[i] <= cmd_data[`BIT_LATCH_HOLD];
			else if (cmd_wr[P])
				hold_reg[i] <= cmd_data[`BIT_PARTNER_LATCH_HOLD];
		end

		always_ff @(posedge clk or negedge rstn)
		begin
			if (!rstn)
			begin
				latch_reg[i]    <= LATCH_TRACE;
				snapshot_reg[i] <= `RESET_WORD;
			end
			else
			begin
				case (latch_reg[i])
				LATCH_TRACE:
				begin
					snapshot_reg[i] <= count_reg[i];
					if (hold_reg[i])
						latch_reg[i] <= LATCH_GRAB;
				end
				LATCH_GRAB:
				begin
					snapshot_reg[i] <= count_reg[i];
					latch_reg[i]    <= hold_reg[i] ? LATCH_DONE
						: LATCH_TRACE;
				end
				LATCH_DONE:
				begin
					if (!hold_reg[i])
						latch_reg[i] <= LATCH_TRACE;
				end
				default: latch_reg[i] <= LATCH_TRACE;
				endcase
			end
		end

		always_comb
		begin
			aux_word[i][0] = load_a_reg[i][write_bank[i]];
			aux_word[i][1] = load_b_reg[i][write_bank[i]];
			aux_word[i][2] = snapshot_reg[i];
			aux_word[i][3] = `RESET_WORD;
			aux_word[i][3][`ST_ARMED]       = armed_reg[i];
			aux_word[i][3][`ST_LATCH_DONE]  = latch_reg[i] == LATCH_DONE;
			aux_word[i][3][`ST_BANK]        = active_bank[i];
			aux_word[i][3][`ST_GATE]        = gate_used[i];
			aux_word[i][3][`ST_DIR_UP]      = dir_up[i];
			aux_word[i][3][`ST_ALT_PENDING] = pending_reg[i];
		end

		// ****************************************
		// Checks
		// ****************************************
		sequence hold_entered;
			hold_reg[i] && latch_reg[i] == LATCH_TRACE ##1 hold_reg[i];
		endsequence

		chk_self_arm_sets: assert property (cmd_wr[i]
			&& cmd_data[`BIT_SELF_ARM] && !disarm_req[i] |=> armed_reg[i])
			else $error("arm command did not arm counter");
		chk_partner_arm_sets: assert property (cmd_wr[P]
			&& cmd_data[`BIT_PARTNER_ARM] && !disarm_req[i]
			|=> (armed_reg[i] && disarm_req[i]) or armed_reg[i] [*2])
			else $error("partner arm did not arm counter");
		chk_self_disarm_clears: assert property (cmd_wr[i]
			&& cmd_data[`BIT_SELF_DISARM] |=> !armed_reg[i])
			else $error("disarm command left counter armed");
		chk_partner_disarm_clears: assert property (cmd_wr[P]
			&& cmd_data[`BIT_PARTNER_DISARM] |=> !armed_reg[i])
			else $error("partner disarm left counter armed");
		chk_latch_hold_done: assert property (hold_entered
			|=> latch_reg[i] == LATCH_DONE ##1
			(!hold_reg[i] || $stable(snapshot_reg[i])))
			else $error("snapshot did not latch and flag");
		chk_idle_bank_select: assert property (!armed_reg[i]
			|=> active_bank[i] == $past(cfg_reg[i].alt_enable))
			else $error("disarmed bank does not follow enable");
		chk_soft_switch_flip: assert property (pending_reg[i]
			&& armed_reg[i] && cfg_reg[i].alt_enable
			&& cfg_reg[i].alt_trigger |=> active_bank[i] != $past(active_bank[i]))
			else $error("software bank switch missing");
		chk_go_self_clear: assert property (switch_now[i]
			&& !go_set[i] |=> !pending_reg[i])
			else $error("bank switch request not cleared");
		chk_ack_half_store: assert property (cmd_wr[i]
			|=> ack_half_select[i] == $past(cmd_data[`BIT_ACK_HALF]))
			else $error("ack half select not stored");
		chk_gate_resync_path: assert property (cfg_reg[i].resync
			&& $stable(gate_pin[i]) [*5] |-> gate_used[i] == gate_pin[i])
			else $error("resynchronised gate does not follow pin");
		chk_preload_transfer: assert property (cmd_wr[i]
			&& cmd_data[`BIT_PRELOAD_STROBE]
			|=> count_reg[i] == $past(load_a_reg[i][active_bank[i]]))
			else $error("load strobe did not transfer value");
		chk_count_down_step: assert property (armed_reg[i]
			&& source_sync[i] && !src_prev_reg[i] && cfg_reg[i].dir == DIR_DOWN
			&& !cmd_wr[i] |=> count_reg[i] == $past(count_reg[i]) - 32'h0000_0001)
			else $error("down count step wrong");
	end
	endgenerate

endmodule // counter_pair_command

// >>> input_sync.sv
`timescale 1ns/1ps

module input_sync
(
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic pin,
	output logic      level
);

	logic stage1_reg;
	logic stage2_reg;
	logic stage3_reg;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stage1_reg <= 1'b0;
			stage2_reg <= 1'b0;
			stage3_reg <= 1'b0;
		end
		else
		begin
			stage1_reg <= pin;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
		end
	end

	// Accept a new level only once the last two stages agree
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			level <= 1'b0;
		else if (stage2_reg == stage3_reg)
			level <= stage3_reg;
	end

endmodule // input_sync

// >>> tb_top.sv
`timescale 1ns/1ps
`include "counter_cmd_map.svh"

module tb_top;

	// ****************************************
	// Signals and addresses
	// ****************************************
	logic        clk;
	logic        rstn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	wire         hready;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [3:0]  count_source_input;
	logic [3:0]  gate_pin;
	logic [3:0]  updown_pin;
	logic [3:0]  ack_half_select;
	logic [3:0]  active_bank;
	int          fails;
	int          n_tests;

	localparam logic [13:0] C0  = `CMD_ADDR0;
	localparam logic [13:0] C1  = `CMD_ADDR1;
	localparam logic [13:0] C2  = `CMD_ADDR2;
	localparam logic [13:0] C3  = `CMD_ADDR3;
	localparam logic [13:0] S0  = 14'h080C;
	localparam logic [13:0] S1  = 14'h081C;
	localparam logic [13:0] S2  = 14'h082C;
	localparam logic [13:0] S3  = 14'h083C;
	localparam logic [13:0] LA0 = 14'h0800;
	localparam logic [13:0] SN0 = 14'h0808;

	typedef struct packed
	{
		logic [13:0] a;
		logic [15:0] w;
		logic [13:0] r;
		logic [7:0]  e;
	} row_type;

	// Command written, status address read, status expected
	row_type rows [16] = '{
		'{C0, 16'h0001, S0, 8'h01},
		'{C0, 16'h0000, S0, 8'h01},
		'{C0, 16'h0008, S0, 8'h01},
		'{C0, 16'h0010, S0, 8'h00},
		'{C0, 16'h0011, S0, 8'h00},
		'{C0, 16'h2000, S1, 8'h01},
		'{C0, 16'h8000, S1, 8'h00},
		'{C2, 16'h2000, S3, 8'h01},
		'{C3, 16'h0010, S3, 8'h00},
		'{C2, 16'h0001, S2, 8'h01},
		'{C3, 16'h8000, S2, 8'h00},
		'{C1, 16'h0020, S1, 8'h10},
		'{C1, 16'h0040, S1, 8'h10},
		'{C1, 16'h0060, S1, 8'h00},
		'{C1, 16'h1000, S1, 8'h04},
		'{C1, 16'h0000, S1, 8'h00}
	};
	logic [13:0] cmds [4] = '{C0, C1, C2, C3};

	assign hready = hreadyout;

	always #4 clk = ~clk;

	counter_pair_command dut
	(
		.clk                (clk),
		.rstn               (rstn),
		.hsel               (hsel),
		.haddr              (haddr),
		.htrans             (htrans),
		.hwrite             (hwrite),
		.hsize              (hsize),
		.hwdata             (hwdata),
		.hready             (hready),
		.hrdata             (hrdata),
		.hreadyout          (hreadyout),
		.hresp              (hresp),
		.count_source_input (count_source_input),
		.gate_pin           (gate_pin),
		.updown_pin         (updown_pin),
		.ack_half_select    (ack_half_select),
		.active_bank        (active_bank)
	);

	// ****************************************
	// Checking and bus tasks
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
		input string nm);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic wait_rdy;
		int i;
		i = 0;
		@(posedge clk);
		while (hreadyout !== 1'b1 && i <= 50)
		begin
			i++;
			@(posedge clk);
		end
		if (hreadyout !== 1'b1)
		begin
			fails++;
			test_done;
		end
	endtask

	// Entered just after a rising edge; returns just after one
	task automatic xfer(input logic wr, input logic [13:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {18'h0_0000, a};
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy;
		rd = hrdata;
	endtask

	task automatic wr(input logic [13:0] a, input logic [15:0] d);
		logic [31:0] rd;
		xfer(1'b1, a, {16'h0000, d}, rd);
		repeat (4) @(posedge clk);
	endtask

	task automatic rdchk(input logic [13:0] a, input logic [31:0] e,
		input string nm);
		logic [31:0] rd;
		xfer(1'b0, a, 32'h0000_0000, rd);
		chk(rd, e, nm);
	endtask

	// Source pulses long enough to pass the input synchroniser
	task automatic pulse(input int k, input int n);
		repeat (n)
		begin
			count_source_input[k] <= 1'b1;
			repeat (4) @(posedge clk);
			count_source_input[k] <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask

	// ****************************************
	// Hang guard
	// ****************************************
	initial
	begin
		repeat (20000) @(posedge clk);
		fails++;
		test_done;
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		clk = 1'b0;
		rstn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		count_source_input = 4'h0;
		gate_pin = 4'h0;
		updown_pin = 4'hF;
		fails = 0;
		n_tests = 0;
		repeat (8) @(posedge clk);
		chk({31'h0, hreadyout}, 32'h0000_0000, "hreadyout in reset");
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		rdchk(S0, 32'h0000_0000, "status after reset");
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].w);
			rdchk(rows[i].r, {24'h00_0000, rows[i].e}, "status");
		end
		// Load strobe, counting, write redirect
		wr(LA0, 16'h1234);
		wr(C0, 16'h0004);
		rdchk(SN0, 32'h0000_1234, "loaded count");
		wr(C0, 16'h0021);
		pulse(0, 3);
		rdchk(SN0, 32'h0000_1237, "count up");
		wr(C0, 16'h00A1);
		wr(LA0, 16'h0055);
		wr(C0, 16'h00A4);
		rdchk(SN0, 32'h0000_1234, "redirected load");
		wr(C0, 16'h0020);
		wr(LA0, 16'h0066);
		wr(C0, 16'h0024);
		rdchk(SN0, 32'h0000_0066, "direct load");
		// Partner snapshot latch from counter 1
		wr(C1, 16'h4000);
		rdchk(S0, 32'h0000_0013, "latch complete");
		pulse(0, 1);
		rdchk(SN0, 32'h0000_0066, "held snapshot");
		wr(C1, 16'h0000);
		rdchk(SN0, 32'h0000_0067, "tracing snapshot");
		wr(C0, 16'h0001);
		pulse(0, 2);
		rdchk(SN0, 32'h0000_0065, "count down");
		wr(C0, 16'h0010);
		// Software bank switch on counter 3
		wr(C3, 16'h1800);
		wr(C3, 16'h1801);
		rdchk(S3, 32'h0000_0005, "armed bank y");
		wr(C3, 16'h1C00);
		rdchk(S3, 32'h0000_0001, "soft switch");
		chk({28'h0, active_bank}, 32'h0000_0000, "active bank");
		// Gate bank switch on counter 2
		wr(C2, 16'h1000);
		wr(C2, 16'h1001);
		wr(C2, 16'h1400);
		rdchk(S2, 32'h0000_0025, "switch pending");
		gate_pin[2] <= 1'b1;
		repeat (6) @(posedge clk);
		rdchk(S2, 32'h0000_0009, "gate switch");
		// Gate resynchronisation delay on counter 0
		wr(C0, 16'h0110);
		gate_pin[0] <= 1'b1;
		rdchk(S0, 32'h0000_0000, "gate not yet synced");
		repeat (6) @(posedge clk);
		rdchk(S0, 32'h0000_0008, "gate synced");
		// Direction from the pin and from the gate on counter 1
		updown_pin[1] <= 1'b0;
		gate_pin[1] <= 1'b1;
		wr(C1, 16'h0040);
		rdchk(S1, 32'h0000_0008, "direction pin low");
		wr(C1, 16'h0060);
		rdchk(S1, 32'h0000_0018, "direction gate high");
		// Acknowledge half select per counter
		foreach (cmds[k])
			wr(cmds[k], 16'h0200);
		chk({28'h0, ack_half_select}, 32'h0000_000F, "ack half");
		wr(C2, 16'h0000);
		chk({28'h0, ack_half_select}, 32'h0000_000B, "ack half");
		// Write-only and unmapped places read zero
		rdchk(C1, 32'h0000_0000, "command readback");
		rdchk(14'h3000, 32'h0000_0000, "unmapped read");
		chk({31'h0, hresp}, 32'h0000_0000, "hresp");
		// Reset in mid-run clears outputs and state
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		chk({23'h00_0000, hreadyout, ack_half_select, active_bank},
			32'h0000_0000, "outputs in reset");
		chk(hrdata, 32'h0000_0000, "hrdata in reset");
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		rdchk(S3, 32'h0000_0000, "status after reset");
		test_done;
	end

endmodule // tb_top
